// ### core/osc_chan_div.sv
// One channel divider with start level and phase offset.
// Assumes run_in comes from the alignment sequencer on the same clock.
`timescale 1ns/10ps
module osc_chan_div
    import osc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Control
    input wire logic run_in,
    input wire osc_div_cfg_t cfg_in,
    // Divided clock
    output logic lvl_out
);

    typedef struct packed {
        logic [5:0] cnt;
        logic lvl;
        logic started;
    } osc_dv_t;

    osc_dv_t st_r;
    osc_dv_t st_nxt;
    logic [5:0] delay;
    logic [5:0] phase_len;

    // Start high also waits out one low phase (m plus one) after the offset
    assign delay = cfg_in.start_high ?
        6'({2'b00, cfg_in.phase}) + 6'({2'b00, cfg_in.m}) + 6'h01 :
        6'({2'b00, cfg_in.phase});
    // Fields hold count minus one
    assign phase_len = st_r.lvl ? 6'({2'b00, cfg_in.m}) :
        6'({2'b00, cfg_in.n});

    always_comb begin
        st_nxt = st_r;
        if (!run_in) begin
            st_nxt.lvl = cfg_in.start_high;
            st_nxt.cnt = delay;
            st_nxt.started = 1'b0;
        end else if (st_r.cnt == 6'h00) begin
            st_nxt.started = 1'b1;
            st_nxt.lvl = ~st_r.lvl;
            st_nxt.cnt = phase_len;
        end else begin
            st_nxt.cnt = st_r.cnt - 6'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl_out = st_r.lvl;

endmodule

// ### core/osc_core.sv
// Output alignment, reset modes and driver control of a clock
// distribution device.
// Assumes a serial port front end that turns host transfers into
// single-cycle register strobes on clk_in and marks each serial clock.
//
// What this block does
// - Alignment pin low then high realigns outputs
// - Soft sync, soft reset, distribution power-down realign
// - Power-up, reset pin, power-down pin realign
// - Ignore bit keeps a channel free running
// - Held outputs sit at start-high level
// - Clocking restarts 14-15 plus one cycles
// - Restart may shift by one input cycle
// - Channel alignment applies to all its drivers
// - Single-ended mode turns on both outputs
// - Two enable bits; disabled single-ended tristates
// - Bits one-two set swing; polarity selectable
// - Distribution power-down shuts all differential drivers
// - Safe off by driver, channel or sleep
// - Power-on loads settings, aligns, then toggles
// - Reset pin restores settings, then aligns
// - Restart about 2 us or 20 ms
// - Bits two and five soft reset device
// - Those bits self-clear; others keep value
// - Reset ends after one more serial clock
// - Count fields hold cycles minus one
`timescale 1ns/10ps
module osc_core
    import osc_pkg::*;
#(
    parameter int unsigned P_POR_WAIT_CYC = POR_WAIT_CYC,
    parameter int unsigned P_NV_WAIT_CYC = NV_WAIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Device pins
    input wire logic sync_pin_n_in,
    input wire logic reset_pin_n_in,
    input wire logic power_down_pin_n_in,
    input wire logic cfg_src_pin_in,
    // Register strobes from the serial port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic sclk_edge_in,
    output logic [7:0] reg_rdata_out,
    // Outputs and status
    output osc_drv_t [NUM_OUT-1:0] drv_out,
    output logic [NUM_CH-1:0] ch_clk_out,
    output logic align_busy_out,
    output logic nv_load_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        osc_st_t st;
        logic [31:0] tmr;
        logic nv;
        logic [7:0] spc;
        logic srst;
        logic [7:0] dc_stg;
        logic [7:0] dc_act;
        logic [NUM_OUT-1:0][7:0] out_stg;
        logic [NUM_OUT-1:0][7:0] out_act;
        logic [NUM_OUT-1:0][7:0] div_stg;
        logic [NUM_OUT-1:0][7:0] div_act;
        logic [7:0] rdata;
        osc_drv_t [NUM_OUT-1:0] drv;
    } osc_core_t;

    osc_core_t st_r;
    osc_core_t st_nxt;

    logic sync_hi;
    logic rst_hi;
    logic pd_hi;
    logic cfg_hi;
    logic hold_req;
    logic [NUM_CH-1:0] ch_run;
    logic [NUM_CH-1:0] ch_lvl;
    osc_div_cfg_t [NUM_CH-1:0] ch_cfg;
    logic [9:0] out_idx;
    logic [9:0] div_idx;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Alignment pin is asynchronous; restart timing may slip one cycle
    osc_sync3 #(.RST_VAL(1'b1)) u_sync_pin (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pin_in(sync_pin_n_in),
        .lvl_out(sync_hi)
    );

    // A reset pulse shorter than two clocks may be missed
    osc_sync3 #(.RST_VAL(1'b1)) u_rst_pin (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pin_in(reset_pin_n_in),
        .lvl_out(rst_hi)
    );

    osc_sync3 #(.RST_VAL(1'b1)) u_pd_pin (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pin_in(power_down_pin_n_in),
        .lvl_out(pd_hi)
    );

    osc_sync3 #(.RST_VAL(1'b0)) u_cfg_pin (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pin_in(cfg_src_pin_in),
        .lvl_out(cfg_hi)
    );

    // ------------------------------------------------------------------
    // Channel dividers
    // ------------------------------------------------------------------
    assign hold_req = ~sync_hi | st_r.dc_act[DC_SOFT_SYNC]
        | st_r.dc_act[DC_DIST_PD] | ~pd_hi | st_r.srst;

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            assign ch_cfg[c].m = st_r.div_act[3*c][7:4];
            assign ch_cfg[c].n = st_r.div_act[3*c][3:0];
            assign ch_cfg[c].phase = st_r.div_act[3*c+1][3:0];
            assign ch_cfg[c].start_high = st_r.div_act[3*c+1][DV_START_HIGH];
            // Excluded channels keep toggling through an alignment
            assign ch_run[c] = ((st_r.st == ST_RUN)
                | (st_r.div_act[3*c+1][DV_IGNORE] & (st_r.st != ST_LOAD)))
                & ~st_r.div_act[3*c+2][DV_CH_PD] & pd_hi
                & ~st_r.dc_act[DC_DIST_PD];

            osc_chan_div u_div (
                .clk_in(clk_in),
                .rstn_in(rstn_in),
                .run_in(ch_run[c]),
                .cfg_in(ch_cfg[c]),
                .lvl_out(ch_lvl[c])
            );
        end
    endgenerate

    assign out_idx = reg_addr_in - ADDR_OUT_BASE;
    assign div_idx = reg_addr_in - ADDR_DIV_BASE;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic on;
        logic cm;
        logic [7:0] oc;
        int unsigned ch;
        on = 1'b0;
        cm = 1'b0;
        oc = 8'h00;
        ch = 0;
        st_nxt = st_r;
        st_nxt.nv = cfg_hi;

        // Self-clear first, so that a new soft reset write wins
        if (st_r.srst
            & (st_r.spc[SPC_SRST_LO] | st_r.spc[SPC_SRST_HI])) begin
            st_nxt.spc[SPC_SRST_LO] = 1'b0;
            st_nxt.spc[SPC_SRST_HI] = 1'b0;
        end else if (st_r.srst & sclk_edge_in) begin
            st_nxt.srst = 1'b0;
        end

        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == ADDR_SERIAL_PORT_CONFIG) begin
                st_nxt.spc = reg_wdata_in;
                // Either bit of the mirrored pair starts a soft reset
                if (reg_wdata_in[SPC_SRST_LO] | reg_wdata_in[SPC_SRST_HI])
                begin
                    st_nxt.spc[SPC_SRST_LO] = 1'b1;
                    st_nxt.spc[SPC_SRST_HI] = 1'b1;
                    st_nxt.srst = 1'b1;
                end
            end else if (reg_addr_in >= ADDR_OUT_BASE
                && out_idx < 10'(NUM_OUT)) begin
                st_nxt.out_stg[out_idx[3:0]] = reg_wdata_in;
            end else if (reg_addr_in >= ADDR_DIV_BASE
                && div_idx < 10'(NUM_OUT)) begin
                st_nxt.div_stg[div_idx[3:0]] = reg_wdata_in;
            end else if (reg_addr_in == ADDR_DISTRIBUTION_CONTROL) begin
                st_nxt.dc_stg = reg_wdata_in;
            end else if (reg_addr_in == ADDR_REGISTER_UPDATE
                && reg_wdata_in[RU_UPDATE]) begin
                // Buffered settings act only on update
                st_nxt.dc_act = st_r.dc_stg;
                st_nxt.div_act = st_r.div_stg;
                for (int k = 0; k < NUM_OUT; k++) begin
                    st_nxt.out_act[k] = st_r.out_stg[k];
                    if (st_r.out_stg[k][OC_CMOS_MODE]
                        & ~st_r.out_act[k][OC_CMOS_MODE]) begin
                        st_nxt.out_act[k][OC_EN_A] = 1'b1;
                        st_nxt.out_act[k][OC_EN_B] = 1'b1;
                        st_nxt.out_stg[k][OC_EN_A] = 1'b1;
                        st_nxt.out_stg[k][OC_EN_B] = 1'b1;
                    end
                end
            end
        end

        // Reset pin or soft reset restores settings, except spc
        if (~rst_hi | st_r.srst) begin
            st_nxt.dc_stg = RST_DC;
            st_nxt.dc_act = RST_DC;
            st_nxt.out_stg = {NUM_OUT{RST_OUT}};
            st_nxt.out_act = {NUM_OUT{RST_OUT}};
            st_nxt.div_stg = {NUM_OUT{RST_DIV}};
            st_nxt.div_act = {NUM_OUT{RST_DIV}};
            st_nxt.st = ST_LOAD;
            st_nxt.tmr = cfg_hi ? P_NV_WAIT_CYC : DEF_WAIT_CYC;
        end else begin
            case (st_r.st)
                ST_LOAD: begin
                    if (st_r.tmr == 32'h0) begin
                        st_nxt.st = ST_HOLD;
                    end else begin
                        st_nxt.tmr = st_r.tmr - 32'h1;
                    end
                end
                ST_HOLD: begin
                    if (!hold_req) begin
                        st_nxt.st = ST_PIPE;
                        st_nxt.tmr = PIPE_LD;
                    end
                end
                ST_PIPE: begin
                    if (hold_req) begin
                        st_nxt.st = ST_HOLD;
                    end else if (st_r.tmr == 32'h0) begin
                        st_nxt.st = ST_RUN;
                    end else begin
                        st_nxt.tmr = st_r.tmr - 32'h1;
                    end
                end
                ST_RUN: begin
                    if (hold_req) begin
                        st_nxt.st = ST_HOLD;
                    end
                end
                default: begin
                    st_nxt.st = ST_HOLD;
                end
            endcase
        end

        // Register reads
        if (reg_rd_in) begin
            if (reg_addr_in == ADDR_SERIAL_PORT_CONFIG) begin
                st_nxt.rdata = st_r.spc;
            end else if (reg_addr_in >= ADDR_OUT_BASE
                && out_idx < 10'(NUM_OUT)) begin
                st_nxt.rdata = st_r.out_stg[out_idx[3:0]];
            end else if (reg_addr_in >= ADDR_DIV_BASE
                && div_idx < 10'(NUM_OUT)) begin
                st_nxt.rdata = st_r.div_stg[div_idx[3:0]];
            end else if (reg_addr_in == ADDR_DISTRIBUTION_CONTROL) begin
                st_nxt.rdata = st_r.dc_stg;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end

        // Output drivers follow their channel divider
        for (int k = 0; k < NUM_OUT; k++) begin
            ch = k / OUT_PER_CH;
            oc = st_r.out_act[k];
            cm = oc[OC_CMOS_MODE];
            // Sleep, channel and driver power-down all give safe off
            on = ~oc[OC_PD] & ~st_r.div_act[3*ch+2][DV_CH_PD]
                & pd_hi & ~st_r.dc_act[DC_DIST_PD];
            st_nxt.drv[k].diff_on = on & ~cm;
            // Total power-down drops the safe bias too
            st_nxt.drv[k].safe_off = ~(on & ~cm)
                & ~st_r.dc_act[DC_DIST_PD];
            st_nxt.drv[k].swing = oc[OC_SWING_LO+1:OC_SWING_LO];
            st_nxt.drv[k].diff_lvl = ch_lvl[ch] ^ oc[OC_INV_A];
            st_nxt.drv[k].cmos_a = ch_lvl[ch] ^ oc[OC_INV_A];
            st_nxt.drv[k].cmos_b = ch_lvl[ch] ^ oc[OC_INV_B];
            st_nxt.drv[k].cmos_a_oe = on & cm & oc[OC_EN_A];
            st_nxt.drv[k].cmos_b_oe = on & cm & oc[OC_EN_B];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r.st <= ST_LOAD;
            st_r.tmr <= P_POR_WAIT_CYC;
            st_r.nv <= 1'b0;
            st_r.spc <= RST_SPC;
            st_r.srst <= 1'b0;
            st_r.dc_stg <= RST_DC;
            st_r.dc_act <= RST_DC;
            st_r.out_stg <= {NUM_OUT{RST_OUT}};
            st_r.out_act <= {NUM_OUT{RST_OUT}};
            st_r.div_stg <= {NUM_OUT{RST_DIV}};
            st_r.div_act <= {NUM_OUT{RST_DIV}};
            st_r.rdata <= 8'h00;
            st_r.drv <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.rdata;
    assign drv_out = st_r.drv;
    assign ch_clk_out = ch_lvl;
    assign align_busy_out = (st_r.st != ST_RUN);
    assign nv_load_out = st_r.nv & (st_r.st == ST_LOAD);

endmodule

// ### core/osc_pkg.sv
// Constants, field layouts and carrier types of the output alignment
// and reset control block.
// Assumes one 40 MHz clock that also stands for the channel divider input.
package osc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned POR_WAIT_MS = 70;
    localparam int unsigned NV_WAIT_MS = 20;
    localparam int unsigned DEF_WAIT_NS = 2000;
    localparam int unsigned POR_WAIT_CYC = POR_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned NV_WAIT_CYC = NV_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned DEF_WAIT_CYC =
        DEF_WAIT_NS * (CLK_HZ / 1000000) / 1000;
    localparam int unsigned SYNC_PIPE_MIN_CYC = 14;
    localparam int unsigned SYNC_EXTRA_CYC = 1;
    localparam int unsigned SYNC_LAT_CYC = 5;
    localparam logic [31:0] PIPE_LD = 32'(SYNC_PIPE_MIN_CYC
        + SYNC_EXTRA_CYC - SYNC_LAT_CYC - 1);

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [9:0] ADDR_SERIAL_PORT_CONFIG = 10'h000;
    localparam logic [9:0] ADDR_OUT_BASE = 10'h0f0;
    localparam logic [9:0] ADDR_DIV_BASE = 10'h190;
    localparam logic [9:0] ADDR_DISTRIBUTION_CONTROL = 10'h230;
    localparam logic [9:0] ADDR_REGISTER_UPDATE = 10'h232;
    localparam int unsigned NUM_OUT = 12;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned OUT_PER_CH = 3;

    // serial_port_config
    localparam int unsigned SPC_SRST_LO = 2;
    localparam int unsigned SPC_SRST_HI = 5;
    // distribution_control
    localparam int unsigned DC_SOFT_SYNC = 0;
    localparam int unsigned DC_DIST_PD = 1;
    // register_update
    localparam int unsigned RU_UPDATE = 0;
    // Per-output control
    localparam int unsigned OC_PD = 0;
    localparam int unsigned OC_SWING_LO = 1;
    localparam int unsigned OC_CMOS_MODE = 3;
    localparam int unsigned OC_INV_A = 4;
    localparam int unsigned OC_EN_A = 5;
    localparam int unsigned OC_EN_B = 6;
    localparam int unsigned OC_INV_B = 7;
    // Divider bytes: +0 low/high counts, +1 start/phase/ignore, +2 power
    localparam int unsigned DV_START_HIGH = 4;
    localparam int unsigned DV_IGNORE = 7;
    localparam int unsigned DV_CH_PD = 2;

    // Values after reset
    localparam logic [7:0] RST_SPC = 8'h00;
    localparam logic [7:0] RST_DC = 8'h00;
    localparam logic [7:0] RST_OUT = 8'h04;
    localparam logic [7:0] RST_DIV = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_LOAD = 4'h1,
        ST_HOLD = 4'h2,
        ST_PIPE = 4'h4,
        ST_RUN = 4'h8
    } osc_st_t;

    typedef struct packed {
        logic diff_on;
        logic safe_off;
        logic [1:0] swing;
        logic diff_lvl;
        logic cmos_a;
        logic cmos_a_oe;
        logic cmos_b;
        logic cmos_b_oe;
    } osc_drv_t;

    typedef struct packed {
        logic [3:0] m;
        logic [3:0] n;
        logic [3:0] phase;
        logic start_high;
    } osc_div_cfg_t;

endpackage

// ### core/osc_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin; the output changes once stages two and
// three agree.
`timescale 1ns/10ps
module osc_sync3
    import osc_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Pin and result
    input wire logic pin_in,
    output logic lvl_out
);

    typedef struct packed {
        logic [2:0] ff;
        logic lvl;
    } osc_s3_t;

    osc_s3_t st_r;
    osc_s3_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ff = {st_r.ff[1:0], pin_in};
        // First stage feeds only the second one
        if (st_r.ff[1] == st_r.ff[2]) begin
            st_nxt.lvl = st_r.ff[2];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= {{3{RST_VAL}}, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl_out = st_r.lvl;

endmodule

// ### test/osc_core_bench.sv
// Self-checking bench for the alignment and reset control block.
// Assumes short wait parameters so power-on is 50 cycles.
`timescale 1ns/10ps
module osc_core_bench;
    import osc_pkg::*;
    logic clk_in, rstn_in, sy, rs, pd, cf, wr, rd, sc, busy, nv;
    logic [9:0] ad;
    logic [7:0] wd, rdat, v, a;
    osc_drv_t [NUM_OUT-1:0] drv;
    logic [NUM_CH-1:0] ch;
    int miscompares = 0;
    int n_compared = 0;
    int n;
    osc_host u_host (.clk_in(clk_in), .sync_n_out(sy), .rst_n_out(rs),
        .pd_n_out(pd), .cfg_out(cf), .wr_out(wr), .rd_out(rd),
        .addr_out(ad), .wdata_out(wd), .sclk_out(sc), .rdata_in(rdat));
    osc_core #(.P_POR_WAIT_CYC(50), .P_NV_WAIT_CYC(40)) u_osc_core (
        .clk_in(clk_in), .rstn_in(rstn_in), .sync_pin_n_in(sy),
        .reset_pin_n_in(rs), .power_down_pin_n_in(pd),
        .cfg_src_pin_in(cf), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(ad), .reg_wdata_in(wd), .sclk_edge_in(sc),
        .reg_rdata_out(rdat), .drv_out(drv), .ch_clk_out(ch),
        .align_busy_out(busy), .nv_load_out(nv));
    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [9:0] ra, input logic [7:0] e);
        u_host.rd(ra, v);
        chk("reg", e, v);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask
    // Bounded wait; running out counts a mismatch and ends the run
    task automatic wait_idle(input int lim);
        n = 0;
        while (busy !== 1'b0 && n < lim) begin
            cyc(1);
            n++;
        end
        chk("idle", 8'h00, {7'h00, busy});
        if (n >= lim) complete_run();
    endtask
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        rstn_in = 1'b0;
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        wait_idle(400);
        rchk(10'h0f0, 8'h04);
        rchk(10'h3ff, 8'h00);
        rchk(10'h232, 8'h00);
        $display("test regs done");
        u_host.wr(10'h194, 8'h80);
        u_host.wr(10'h197, 8'h10);
        u_host.upd();
        @(posedge clk_in) u_host.sync_n_out <= 1'b0;
        cyc(10);
        chk("busy", 8'h01, {7'h00, busy});
        chk("held", 8'h01, {7'h00, ch[2]});
        chk("drv", 8'h01, {7'h00, drv[8].diff_lvl});
        a = {7'h00, ch[1]};
        cyc(1);
        chk("free", {7'h00, ~a[0]}, {7'h00, ch[1]});
        @(posedge clk_in) u_host.sync_n_out <= 1'b1;
        n = 0;
        while (ch[0] !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk("delay", 8'h01, {7'h00, n >= 15 && n <= 17});
        $display("test pin done");
        u_host.wr(10'h230, 8'h01);
        u_host.upd();
        cyc(3);
        chk("busy", 8'h01, {7'h00, busy});
        u_host.wr(10'h230, 8'h00);
        u_host.upd();
        wait_idle(60);
        $display("test soft sync done");
        u_host.wr(10'h0f1, 8'h06);
        u_host.wr(10'h0f2, 8'h08);
        u_host.wr(10'h0f3, 8'h01);
        u_host.upd();
        cyc(3);
        chk("swing", 8'h03, {6'h00, drv[1].swing});
        chk("oe", 8'h01, {7'h00, drv[2].cmos_a_oe});
        chk("safe", 8'h01, {7'h00, drv[3].safe_off});
        rchk(10'h0f2, 8'h68);
        u_host.wr(10'h0f2, 8'h28);
        u_host.upd();
        cyc(3);
        chk("oe", 8'h00, {7'h00, drv[2].cmos_b_oe});
        $display("test drivers done");
        u_host.wr(10'h230, 8'h02);
        u_host.upd();
        cyc(3);
        chk("pd", 8'h00, {7'h00, drv[0].diff_on});
        chk("busy", 8'h01, {7'h00, busy});
        u_host.wr(10'h230, 8'h00);
        u_host.upd();
        wait_idle(60);
        @(posedge clk_in) u_host.pd_n_out <= 1'b0;
        cyc(8);
        chk("sleep", 8'h01, {7'h00, drv[0].safe_off});
        chk("tri", 8'h00, {7'h00, drv[2].cmos_a_oe});
        @(posedge clk_in) u_host.pd_n_out <= 1'b1;
        wait_idle(60);
        $display("test power down done");
        u_host.wr(10'h000, 8'h80);
        u_host.wr(10'h000, 8'ha0);
        cyc(2);
        rchk(10'h000, 8'h80);
        cyc(150);
        chk("busy", 8'h01, {7'h00, busy});
        u_host.sclk();
        wait_idle(300);
        rchk(10'h0f1, 8'h04);
        rchk(10'h000, 8'h80);
        $display("test soft reset done");
        u_host.wr(10'h0f1, 8'h06);
        u_host.upd();
        @(posedge clk_in) u_host.cfg_out <= 1'b1;
        @(posedge clk_in) u_host.rst_n_out <= 1'b0;
        cyc(6);
        chk("busy", 8'h01, {7'h00, busy});
        chk("nv", 8'h01, {7'h00, nv});
        @(posedge clk_in) u_host.rst_n_out <= 1'b1;
        rchk(10'h0f1, 8'h04);
        wait_idle(300);
        $display("test reset pin done");
        complete_run();
    end
endmodule

// ### test/osc_core_monitor.sv
// Checker for the alignment and reset control block.
// Assumes it is bound to osc_core and sees only its ports.
`timescale 1ns/10ps
module osc_core_monitor
    import osc_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic sync_pin_n_in,
    input wire logic power_down_pin_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic sclk_edge_in,
    // Outputs
    input wire logic [7:0] reg_rdata_out,
    input wire osc_drv_t [NUM_OUT-1:0] drv_out,
    input wire logic align_busy_out
);
    // -----------------------------------------------------------------
    // Helpers and properties
    // -----------------------------------------------------------------
    logic any_on, any_oe, oe_clash, safe_clash;
    always_comb begin
        any_on = 1'b0;
        any_oe = 1'b0;
        oe_clash = 1'b0;
        safe_clash = 1'b0;
        for (int k = 0; k < NUM_OUT; k++) begin
            any_on |= drv_out[k].diff_on;
            any_oe |= drv_out[k].cmos_a_oe | drv_out[k].cmos_b_oe;
            oe_clash |= drv_out[k].diff_on & drv_out[k].cmos_a_oe;
            safe_clash |= drv_out[k].diff_on & drv_out[k].safe_off;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence srst_wr;
        reg_wr_in && reg_addr_in == ADDR_SERIAL_PORT_CONFIG &&
            reg_wdata_in[SPC_SRST_HI];
    endsequence
    sync_hold_a: assert property (
        !sync_pin_n_in [*8] |-> align_busy_out)
        else $error("busy missing while pin held low");
    pipe_hold_a: assert property (
        $rose(sync_pin_n_in) && align_busy_out |=> align_busy_out [*8])
        else $error("restart came too early");
    pd_quiet_a: assert property (
        !power_down_pin_n_in [*8] |-> !any_on && !any_oe)
        else $error("driver active in sleep");
    oe_excl_a: assert property (!oe_clash)
        else $error("single ended and differential both on");
    safe_excl_a: assert property (!safe_clash)
        else $error("safe off with driver on");
    srst_busy_a: assert property (srst_wr |-> ##[1:3] align_busy_out)
        else $error("soft reset did not stop outputs");
    srst_sclk_a: assert property (
        srst_wr ##1 (!sclk_edge_in) [*4] |-> align_busy_out)
        else $error("soft reset ended without serial clock");
    upd_read_a: assert property (
        reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_REGISTER_UPDATE
        |=> reg_rdata_out == 8'h00)
        else $error("update register read not zero");
    pin_filter_a: assert property (
        $fell(sync_pin_n_in) && !align_busy_out |=> !align_busy_out)
        else $error("pin acted before synchroniser");
    cover property ($rose(sync_pin_n_in) && align_busy_out);
    cover property (!power_down_pin_n_in [*8]);
    cover property (srst_wr);
endmodule

bind osc_core osc_core_monitor u_osc_core_monitor (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .sync_pin_n_in(sync_pin_n_in),
    .power_down_pin_n_in(power_down_pin_n_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .sclk_edge_in(sclk_edge_in),
    .reg_rdata_out(reg_rdata_out),
    .drv_out(drv_out),
    .align_busy_out(align_busy_out)
);

// ### test/osc_host.sv
// Host controller model: pins and register strobes.
// Assumes the serial front end has turned transfers into strobes.
`timescale 1ns/10ps
module osc_host (
    // Clock
    input wire logic clk_in,
    // Pins
    output logic sync_n_out,
    output logic rst_n_out,
    output logic pd_n_out,
    output logic cfg_out,
    // Register strobes
    output logic wr_out,
    output logic rd_out,
    output logic [9:0] addr_out,
    output logic [7:0] wdata_out,
    output logic sclk_out,
    input wire logic [7:0] rdata_in
);
    // -----------------------------------------------------------------
    // Access tasks
    // -----------------------------------------------------------------
    initial begin
        {sync_n_out, rst_n_out, pd_n_out} = 3'h7;
        {cfg_out, wr_out, rd_out, sclk_out} = 4'h0;
        addr_out = 10'h000;
        wdata_out = 8'h00;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask
    // New settings only count once an update follows them
    task automatic upd();
        wr(10'h232, 8'h01);
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
        #1;
        d = rdata_in;
    endtask
    // Soft reset only ends on one more serial clock
    task automatic sclk();
        @(posedge clk_in);
        sclk_out <= 1'b1;
        @(posedge clk_in);
        sclk_out <= 1'b0;
    endtask
endmodule
